// ===== verilog/dns_ddc_top.sv
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "dns_cfg.svh"

// What this block does
// - Four free-running accumulators per channel
// - Hop source one selects from pins
// - Hop source zero selects register field
// - Select bits form binary oscillator index
// - Separate frequency and phase word each
// - Divider zero adds frequency word each clock
// - Frequency word wraps modulo two to 32
// - Frequency rewrite needs new synchronisation
// - Nonzero divider gives exact rational frequency
// - Phase offset added in upper half
// - SYNC low arms, SYNC rise synchronises
// - SYNC synchronisation honoured in 64b66b
// - DC SYSREF: armed, next pulse synchronises
// - AC SYSREF: next rising edge after arm
// - Arm acts at write completion edge
// - Linear-phase complex filters, 15-bit output
// - Decimation by 4, 8, 16, 32
// - Bypass passes real 12-bit samples
// - Stop-band and alias-protected bandwidth targets; the boxcar filters fall short of them
// - Hop pins resynchronised before use
// - Real sample mixed with complex exponential
module dns_ddc_top import dns_pkg::*; #(
  parameter int SW = `DNS_SAMPLE_W,
  parameter int MW = `DNS_MIX_W,
  parameter int OW = `DNS_OUT_W
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [1:0]           chan_a_hop_select_pins,
  input  wire logic [1:0]           chan_b_hop_select_pins,
  input  wire logic                 single_ended_sync_pin,
  input  wire logic                 sysref_pin,
  input  wire logic signed [SW-1:0] adc_sample_a,
  input  wire logic signed [SW-1:0] adc_sample_b,
  output logic signed [OW-1:0]      out_a_i,
  output logic signed [OW-1:0]      out_a_q,
  output logic                      out_a_valid,
  output logic signed [OW-1:0]      out_b_i,
  output logic signed [OW-1:0]      out_b_q,
  output logic                      out_b_valid,
  output logic                      cgs_start,
  output logic                      nco_sync_event
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic                 hop_source_select;
    logic                 link_init_sync_enable;
    logic                 next_sysref_sync_arm;
    logic                 link_enable;
    logic                 bypass;
    dns_dec_t             dec_sel;
    logic                 enc64;
    logic [1:0]           chan_a_osc_select_field;
    logic [1:0]           chan_b_osc_select_field;
    logic [15:0]          rational_divider;
    logic [3:0][31:0]     chan_a_freq_word;
    logic [3:0][31:0]     chan_b_freq_word;
    logic [3:0][15:0]     chan_a_phase_offset;
    logic [3:0][15:0]     chan_b_phase_offset;
    logic [3:0]           hop_s1;
    logic [3:0]           hop_s2;
    logic [3:0]           hop_s3;
    logic [3:0]           hop_lvl;
    logic [1:0]           pin_s1;
    logic [1:0]           pin_s2;
    logic [1:0]           pin_s3;
    logic [1:0]           pin_lvl;
    dns_sync_st_t         st;
    logic                 sync_pulse;
    logic                 cgs;
    logic [7:0]           sync_count;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic signed [OW-1:0] ai;
    logic signed [OW-1:0] aq;
    logic                 av;
    logic signed [OW-1:0] bi;
    logic signed [OW-1:0] bq;
    logic                 bv;
  } dns_top_st_t;

  dns_top_st_t r;
  dns_top_st_t n;

  logic signed [MW-1:0] mix_a_i;
  logic signed [MW-1:0] mix_a_q;
  logic signed [MW-1:0] mix_b_i;
  logic signed [MW-1:0] mix_b_q;
  logic signed [OW-1:0] dec_a_i;
  logic signed [OW-1:0] dec_a_q;
  logic                 dec_a_v;
  logic signed [OW-1:0] dec_b_i;
  logic signed [OW-1:0] dec_b_q;
  logic                 dec_b_v;
  logic [1:0]           sel_a;
  logic [1:0]           sel_b;
  logic [2:0]           dec_log2;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a[1:0] == 2'b00) && (a < `DNS_OFF_END);
  endfunction

  function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
    in_bank = (a[11:4] == base[11:4]);
  endfunction

  // ----------------------------------------
  // Oscillator selection
  // ----------------------------------------
  // Pins only reach the mux after the resynchroniser, never raw
  assign sel_a = r.hop_source_select ? r.hop_lvl[1:0] : r.chan_a_osc_select_field;
  assign sel_b = r.hop_source_select ? r.hop_lvl[3:2] : r.chan_b_osc_select_field;
  assign dec_log2 = 3'(r.dec_sel) + 3'h2;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic        sync_rise;
    logic        sync_fall;
    logic        sysref_rise;
    logic        fire;
    logic        acc_ph;
    logic        wr;
    logic [1:0]  idx;
    logic [31:0] rd;
    sync_rise   = 1'b0;
    sync_fall   = 1'b0;
    sysref_rise = 1'b0;
    fire        = 1'b0;
    acc_ph      = psel & penable;
    wr          = acc_ph & r.pready & pwrite & addr_hit(paddr);
    idx         = paddr[3:2];
    rd          = 32'h00000000;
    n           = r;
    n.pready    = 1'b0;
    n.pslverr   = 1'b0;
    n.sync_pulse = 1'b0;
    n.cgs       = 1'b0;

    // Three-stage resynchronisers; a change counts once stages two and three agree
    n.hop_s1 = {chan_b_hop_select_pins, chan_a_hop_select_pins};
    n.hop_s2 = r.hop_s1;
    n.hop_s3 = r.hop_s2;
    for (int k = 0; k < 4; k++) begin
      if (r.hop_s2[k] == r.hop_s3[k]) begin
        n.hop_lvl[k] = r.hop_s3[k];
      end
    end
    n.pin_s1 = {sysref_pin, single_ended_sync_pin};
    n.pin_s2 = r.pin_s1;
    n.pin_s3 = r.pin_s2;
    for (int k = 0; k < 2; k++) begin
      if (r.pin_s2[k] == r.pin_s3[k]) begin
        n.pin_lvl[k] = r.pin_s3[k];
      end
    end
    sync_rise   = n.pin_lvl[0] & ~r.pin_lvl[0];
    sync_fall   = ~n.pin_lvl[0] & r.pin_lvl[0];
    sysref_rise = n.pin_lvl[1] & ~r.pin_lvl[1];

    // ----------------------------------------
    // SYNC-based synchronisation
    // ----------------------------------------
    // Arming works in both encodings; only 8b/10b also starts code group sync
    unique case (r.st)
      DNS_ST_IDLE: begin
        if (r.link_init_sync_enable && r.link_enable && sync_fall) begin
          n.st  = DNS_ST_ARMED;
          n.cgs = ~r.enc64;
        end
      end
      DNS_ST_ARMED: begin
        if (!(r.link_init_sync_enable && r.link_enable)) begin
          n.st = DNS_ST_IDLE;
        end else if (sync_rise) begin
          n.st = DNS_ST_IDLE;
          fire = 1'b1;
        end
      end
      default: n.st = DNS_ST_IDLE;
    endcase

    // ----------------------------------------
    // SYSREF-based synchronisation
    // ----------------------------------------
    // Only an edge after the arm write counts; a level already high is no edge
    if (r.next_sysref_sync_arm && sysref_rise) begin
      fire                   = 1'b1;
      n.next_sysref_sync_arm = 1'b0;
    end

    if (fire) begin
      n.sync_pulse = 1'b1;
      n.sync_count = r.sync_count + 8'h01;
    end

    // ----------------------------------------
    // APB read data
    // ----------------------------------------
    if (in_bank(paddr, `DNS_OFF_CTRL)) begin
      unique case (idx)
        2'h0: rd = {24'h000000, r.enc64, r.dec_sel, r.bypass, r.link_enable,
                    r.next_sysref_sync_arm, r.link_init_sync_enable,
                    r.hop_source_select};
        2'h1: rd = {28'h0000000, r.chan_b_osc_select_field,
                    r.chan_a_osc_select_field};
        2'h2: rd = {16'h0000, r.rational_divider};
        2'h3: rd = {16'h0000, r.sync_count, 2'b00, r.st == DNS_ST_ARMED,
                    r.next_sysref_sync_arm, sel_b, sel_a};
      endcase
    end else if (in_bank(paddr, `DNS_OFF_FREQA)) begin
      rd = r.chan_a_freq_word[idx];
    end else if (in_bank(paddr, `DNS_OFF_FREQB)) begin
      rd = r.chan_b_freq_word[idx];
    end else if (in_bank(paddr, `DNS_OFF_PHA)) begin
      rd = {16'h0000, r.chan_a_phase_offset[idx]};
    end else if (in_bank(paddr, `DNS_OFF_PHB)) begin
      rd = {16'h0000, r.chan_b_phase_offset[idx]};
    end

    // One wait state: answer registered in the first access cycle
    if (acc_ph && !r.pready) begin
      n.pready  = 1'b1;
      n.pslverr = ~addr_hit(paddr);
      n.prdata  = (pwrite || !addr_hit(paddr)) ? 32'h00000000 : rd;
    end

    // ----------------------------------------
    // APB writes, at the completing edge
    // ----------------------------------------
    if (wr) begin
      if (in_bank(paddr, `DNS_OFF_CTRL)) begin
        unique case (idx)
          2'h0: begin
            n.hop_source_select     = pwdata[`DNS_CTRL_HOP_SRC];
            n.link_init_sync_enable = pwdata[`DNS_CTRL_ILA];
            // Written value applies at this edge; a set beats the auto-clear
            n.next_sysref_sync_arm  = pwdata[`DNS_CTRL_ARM];
            n.link_enable           = pwdata[`DNS_CTRL_LINK];
            n.bypass                = pwdata[`DNS_CTRL_BYP];
            n.dec_sel = dns_dec_t'(pwdata[`DNS_CTRL_DEC_HI:`DNS_CTRL_DEC_LO]);
            n.enc64                 = pwdata[`DNS_CTRL_ENC64];
          end
          2'h1: begin
            n.chan_a_osc_select_field = pwdata[1:0];
            n.chan_b_osc_select_field = pwdata[3:2];
          end
          2'h2: n.rational_divider = pwdata[15:0];
          2'h3: ;
        endcase
      end else if (in_bank(paddr, `DNS_OFF_FREQA)) begin
        // Phase is left running; only a later sync makes it deterministic
        n.chan_a_freq_word[idx] = pwdata;
      end else if (in_bank(paddr, `DNS_OFF_FREQB)) begin
        n.chan_b_freq_word[idx] = pwdata;
      end else if (in_bank(paddr, `DNS_OFF_PHA)) begin
        n.chan_a_phase_offset[idx] = pwdata[15:0];
      end else if (in_bank(paddr, `DNS_OFF_PHB)) begin
        n.chan_b_phase_offset[idx] = pwdata[15:0];
      end
    end

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    if (r.bypass) begin
      n.ai = OW'(adc_sample_a);
      n.aq = '0;
      n.av = 1'b1;
      n.bi = OW'(adc_sample_b);
      n.bq = '0;
      n.bv = 1'b1;
    end else begin
      n.av = dec_a_v;
      n.bv = dec_b_v;
      if (dec_a_v) begin
        n.ai = dec_a_i;
        n.aq = dec_a_q;
      end
      if (dec_b_v) begin
        n.bi = dec_b_i;
        n.bq = dec_b_q;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r    <= '0;
      r.st <= DNS_ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  dns_nco_chan #(.SW(SW), .MW(MW)) u_nco_a (
    .pclk             (pclk),
    .presetn          (presetn),
    .freq_word        (r.chan_a_freq_word),
    .phase_offset     (r.chan_a_phase_offset),
    .rational_divider (r.rational_divider),
    .osc_sel          (sel_a),
    .sync_pulse       (r.sync_pulse),
    .sample_in        (adc_sample_a),
    .mix_i            (mix_a_i),
    .mix_q            (mix_a_q)
  );

  dns_nco_chan #(.SW(SW), .MW(MW)) u_nco_b (
    .pclk             (pclk),
    .presetn          (presetn),
    .freq_word        (r.chan_b_freq_word),
    .phase_offset     (r.chan_b_phase_offset),
    .rational_divider (r.rational_divider),
    .osc_sel          (sel_b),
    .sync_pulse       (r.sync_pulse),
    .sample_in        (adc_sample_b),
    .mix_i            (mix_b_i),
    .mix_q            (mix_b_q)
  );

  // Boxcar decimators fall well short of deep stop-band targets
  dns_decim #(.IW(MW), .OW(OW)) u_dec_a (
    .pclk       (pclk),
    .presetn    (presetn),
    .dec_log2   (dec_log2),
    .din_i      (mix_a_i),
    .din_q      (mix_a_q),
    .dout_i     (dec_a_i),
    .dout_q     (dec_a_q),
    .dout_valid (dec_a_v)
  );

  dns_decim #(.IW(MW), .OW(OW)) u_dec_b (
    .pclk       (pclk),
    .presetn    (presetn),
    .dec_log2   (dec_log2),
    .din_i      (mix_b_i),
    .din_q      (mix_b_q),
    .dout_i     (dec_b_i),
    .dout_q     (dec_b_q),
    .dout_valid (dec_b_v)
  );

  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign out_a_i        = r.ai;
  assign out_a_q        = r.aq;
  assign out_a_valid    = r.av;
  assign out_b_i        = r.bi;
  assign out_b_q        = r.bq;
  assign out_b_valid    = r.bv;
  assign cgs_start      = r.cgs;
  assign nco_sync_event = r.sync_pulse;

endmodule // dns_ddc_top

// ===== verilog/dns_cfg.svh
`ifndef DNS_CFG_SVH
`define DNS_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DNS_OFF_CTRL   12'h000
`define DNS_OFF_SEL    12'h004
`define DNS_OFF_RDIV   12'h008
`define DNS_OFF_STAT   12'h00c
`define DNS_OFF_FREQA  12'h010
`define DNS_OFF_FREQB  12'h020
`define DNS_OFF_PHA    12'h030
`define DNS_OFF_PHB    12'h040
`define DNS_OFF_END    12'h050

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define DNS_CTRL_HOP_SRC  0
`define DNS_CTRL_ILA      1
`define DNS_CTRL_ARM      2
`define DNS_CTRL_LINK     3
`define DNS_CTRL_BYP      4
`define DNS_CTRL_DEC_LO   5
`define DNS_CTRL_DEC_HI   6
`define DNS_CTRL_ENC64    7

// ----------------------------------------
// Reset values and numeric constants
// ----------------------------------------
`define DNS_CTRL_RST      8'h00
`define DNS_RDIV_STEP     22'h000040
`define DNS_SAMPLE_W      12
`define DNS_MIX_W         16
`define DNS_OUT_W         15
`define DNS_CLK_PERIOD_NS 100

`endif

// ===== verilog/dns_pkg.sv
package dns_pkg;

  typedef enum logic [1:0] {
    DNS_ST_IDLE  = 2'b01,
    DNS_ST_ARMED = 2'b10
  } dns_sync_st_t;

  typedef enum logic [1:0] {
    DNS_DEC4  = 2'h0,
    DNS_DEC8  = 2'h1,
    DNS_DEC16 = 2'h2,
    DNS_DEC32 = 2'h3
  } dns_dec_t;

endpackage

// ===== verilog/dns_nco_chan.sv
`timescale 1ns/1ps
`include "dns_cfg.svh"

module dns_nco_chan import dns_pkg::*; #(
  parameter int SW = `DNS_SAMPLE_W,
  parameter int MW = `DNS_MIX_W
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [3:0][31:0]      freq_word,
  input  wire logic [3:0][15:0]      phase_offset,
  input  wire logic [15:0]           rational_divider,
  input  wire logic [1:0]            osc_sel,
  input  wire logic                  sync_pulse,
  input  wire logic signed [SW-1:0]  sample_in,
  output logic signed [MW-1:0]       mix_i,
  output logic signed [MW-1:0]       mix_q
);

  typedef struct packed {
    logic [3:0][31:0]      acc;
    logic [21:0]           modcnt;
    logic signed [MW-1:0]  mi;
    logic signed [MW-1:0]  mq;
  } dns_nco_st_t;

  dns_nco_st_t r;
  dns_nco_st_t n;

  // Quarter-wave table keeps the lookup small; 6 phase bits limit spur level
  function automatic logic signed [11:0] sin_lut(input logic [5:0] ph);
    logic [3:0]  idx;
    logic [10:0] mag;
    idx = ph[4] ? ~ph[3:0] : ph[3:0];
    unique case (idx)
      4'h0: mag = 11'h064;  4'h1: mag = 11'h12c;  4'h2: mag = 11'h1f1;
      4'h3: mag = 11'h2b2;  4'h4: mag = 11'h36b;  4'h5: mag = 11'h41c;
      4'h6: mag = 11'h4c3;  4'h7: mag = 11'h55f;  4'h8: mag = 11'h5ed;
      4'h9: mag = 11'h66c;  4'ha: mag = 11'h6dc;  4'hb: mag = 11'h73b;
      4'hc: mag = 11'h787;  4'hd: mag = 11'h7c2;  4'he: mag = 11'h7e9;
      4'hf: mag = 11'h7fd;
    endcase
    sin_lut = ph[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  always_comb begin
    logic [21:0]          last;
    logic [31:0]          ph;
    logic signed [23:0]   pi_full;
    logic signed [23:0]   pq_full;
    last    = 22'(rational_divider) * `DNS_RDIV_STEP - 22'h000001;
    n       = r;
    n.modcnt = (r.modcnt >= last) ? 22'h000000 : r.modcnt + 22'h000001;
    for (int k = 0; k < 4; k++) begin
      if (sync_pulse) begin
        n.acc[k] = 32'h00000000;
      end else if (rational_divider != 16'h0000 && r.modcnt >= last) begin
        n.acc[k] = 32'h00000000;
      end else begin
        n.acc[k] = r.acc[k] + freq_word[k];
      end
    end
    if (sync_pulse) begin
      n.modcnt = 22'h000000;
    end
    ph      = r.acc[osc_sel] + {phase_offset[osc_sel], 16'h0000};
    pi_full = sample_in * sin_lut(ph[31:26] + 6'h10);
    pq_full = -(sample_in * sin_lut(ph[31:26]));
    n.mi    = pi_full[22:23-MW];
    n.mq    = pq_full[22:23-MW];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign mix_i = r.mi;
  assign mix_q = r.mq;

endmodule // dns_nco_chan

// ===== verilog/dns_decim.sv
`timescale 1ns/1ps
`include "dns_cfg.svh"

module dns_decim #(
  parameter int IW = `DNS_MIX_W,
  parameter int OW = `DNS_OUT_W
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [2:0]           dec_log2,
  input  wire logic signed [IW-1:0] din_i,
  input  wire logic signed [IW-1:0] din_q,
  output logic signed [OW-1:0]      dout_i,
  output logic signed [OW-1:0]      dout_q,
  output logic                      dout_valid
);

  typedef struct packed {
    logic signed [IW+4:0] si;
    logic signed [IW+4:0] sq;
    logic [4:0]           cnt;
    logic signed [OW-1:0] oi;
    logic signed [OW-1:0] oq;
    logic                 ov;
  } dns_dec_st_t;

  dns_dec_st_t r;
  dns_dec_st_t n;

  // Boxcar sum and dump: symmetric taps, so the phase stays linear
  always_comb begin
    logic [4:0]           last;
    logic signed [IW+4:0] ti;
    logic signed [IW+4:0] tq;
    logic signed [IW+4:0] ai;
    logic signed [IW+4:0] aq;
    last = 5'((6'h01 << dec_log2) - 6'h01);
    ti   = r.si + (IW+5)'(din_i);
    tq   = r.sq + (IW+5)'(din_q);
    ai   = ti >>> dec_log2;
    aq   = tq >>> dec_log2;
    n    = r;
    n.ov = 1'b0;
    if (r.cnt >= last) begin
      n.cnt = 5'h00;
      n.si  = '0;
      n.sq  = '0;
      n.oi  = ai[IW-1:IW-OW];
      n.oq  = aq[IW-1:IW-OW];
      n.ov  = 1'b1;
    end else begin
      n.cnt = r.cnt + 5'h01;
      n.si  = ti;
      n.sq  = tq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dout_i     = r.oi;
  assign dout_q     = r.oq;
  assign dout_valid = r.ov;

endmodule // dns_decim

// ===== bench/dns_ddc_props.sv
`timescale 1ns/1ps
// ---
// Port checks
// ---
module dns_ddc_props #(
  parameter int OW = 15
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 single_ended_sync_pin,
  input wire logic                 sysref_pin,
  input wire logic signed [OW-1:0] out_a_i,
  input wire logic signed [OW-1:0] out_a_q,
  input wire logic                 out_a_valid,
  input wire logic                 out_b_valid,
  input wire logic                 cgs_start,
  input wire logic                 nco_sync_event
);
  logic [3:0] rise_age;
  logic [3:0] fall_age;
  logic       sync_d;
  logic       ref_d;
  // Ages saturate so a stale edge never looks recent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_d   <= 1'b1;
      ref_d    <= 1'b0;
      rise_age <= 4'hf;
      fall_age <= 4'hf;
    end else begin
      sync_d   <= single_ended_sync_pin;
      ref_d    <= sysref_pin;
      if ((single_ended_sync_pin && !sync_d) || (sysref_pin && !ref_d)) rise_age <= 4'h0;
      else if (rise_age != 4'hf) rise_age <= rise_age + 4'h1;
      if (!single_ended_sync_pin && sync_d) fall_age <= 4'h0;
      else if (fall_age != 4'hf) fall_age <= fall_age + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_byp;
    out_a_valid && $past(out_a_valid);
  endsequence
  sequence s_fell_a;
    $fell(out_a_valid);
  endsequence
  chk_sync_single: assert property (nco_sync_event |=> !nco_sync_event)
    else $error("sync pulse too long");
  chk_cgs_single: assert property (cgs_start |=> !cgs_start)
    else $error("cgs pulse too long");
  chk_sync_cause: assert property (nco_sync_event |-> rise_age <= 4'h9)
    else $error("sync without edge");
  chk_cgs_cause: assert property (cgs_start |-> fall_age <= 4'h9 && !single_ended_sync_pin)
    else $error("cgs without sync fall");
  chk_valid_a: assert property (s_fell_a |-> !out_a_valid [*3])
    else $error("valid a too dense");
  chk_valid_b: assert property ($fell(out_b_valid) |-> !out_b_valid [*3])
    else $error("valid b too dense");
  chk_bypass_q: assert property (s_byp |-> out_a_q == '0)
    else $error("bypass q not zero");
  chk_bypass_i: assert property (s_byp |-> out_a_i == $signed(out_a_i[11:0]))
    else $error("bypass i not 12 bit");
endmodule // dns_ddc_props

// ===== bench/dns_link_model.sv
`timescale 1ns/1ps
// ---
// Receiver and SYSREF source
// ---
module dns_link_model (
  input  wire logic pclk,
  output logic      sync_pin,
  output logic      sysref
);
  initial begin
    sync_pin = 1'b1;
    sysref   = 1'b0;
  end
  task automatic sync_cycle();
    @(posedge pclk);
    sync_pin <= 1'b0;
    repeat (12) @(posedge pclk);
    sync_pin <= 1'b1;
  endtask
  // Pulses held 4 cycles so the pin filter sees them
  task automatic sysref_run(input int n, input int per);
    repeat (n) begin
      @(posedge pclk);
      sysref <= 1'b1;
      repeat (4) @(posedge pclk);
      sysref <= 1'b0;
      repeat (per - 5) @(posedge pclk);
    end
  endtask
endmodule // dns_link_model

// ===== bench/test_ddc_nco_select_sync_decimation.sv
`timescale 1ns/1ps
module test_ddc_nco_select_sync_decimation;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic r;} dns_row_t;
  localparam dns_row_t ROWS [9] = '{
    '{12'h000, 32'hffffff10, 32'h10, 1'b0}, '{12'h004, 32'hffffff0e, 32'h0e, 1'b0},
    '{12'h008, 32'h12340780, 32'h0780, 1'b0}, '{12'h010, 32'hdeadbeef, 32'hdeadbeef, 1'b0},
    '{12'h02c, 32'h12345678, 32'h12345678, 1'b0}, '{12'h034, 32'hffff1234, 32'h1234, 1'b0},
    '{12'h04c, 32'h0000beef, 32'hbeef, 1'b0}, '{12'h050, 32'h1, 32'h0, 1'b1},
    '{12'h002, 32'h1, 32'h0, 1'b1}};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        av, bv, cgs, sev, sync_w, sysref_w;
  logic [11:0] paddr, smp;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  hop_a, hop_b, sl;
  logic [14:0] ai, aq, bi, bq;
  int          err_total, check_count, cyc, n_cgs, n_sev, n;
  dns_ddc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_a_hop_select_pins(hop_a), .chan_b_hop_select_pins(hop_b),
    .single_ended_sync_pin(sync_w), .sysref_pin(sysref_w), .adc_sample_a(smp),
    .adc_sample_b(smp), .out_a_i(ai), .out_a_q(aq), .out_a_valid(av), .out_b_i(bi),
    .out_b_q(bq), .out_b_valid(bv), .cgs_start(cgs), .nco_sync_event(sev));
  dns_link_model link (.pclk(pclk), .sync_pin(sync_w), .sysref(sysref_w));
  task automatic final_report();
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic watch(input int k);
    n_cgs = 0;
    n_sev = 0;
    repeat (k) begin
      @(posedge pclk);
      n_cgs += cgs;
      n_sev += sev;
    end
  endtask
  task automatic gap();
    n = 0;
    do begin @(posedge pclk); n++; end while (av !== 1'b1);
  endtask
  function automatic logic [1:0] quad(input logic signed [14:0] i, input logic signed [14:0] q);
    int ia, qa;
    ia = (i < 0) ? -i : i;
    qa = (q < 0) ? -q : q;
    if (ia >= qa) return (i < 0) ? 2'd2 : 2'd0;
    return (q < 0) ? 2'd1 : 2'd3;
  endfunction
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge pclk);
      cyc++;
      if (cyc == 20000) begin
        err_total++;
        final_report();
      end
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, hop_a, hop_b} = '0;
    smp = 12'h9ab;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 12'h000, 0);
    chk(rd, 32'h0);
    foreach (ROWS[j]) begin
      apb(1, ROWS[j].a, ROWS[j].d);
      chk(er, ROWS[j].r);
      apb(0, ROWS[j].a, 0);
      chk(rd, ROWS[j].e);
      chk(er, ROWS[j].r);
    end
    repeat (4) @(posedge pclk);
    chk({av, aq, ai}, {1'b1, 15'h0, 15'h79ab});
    // Mid-run reset: rows left accumulators running and bypass on
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({av, aq, ai}, 32'h0);
    apb(0, 12'h008, 0);
    chk(rd, 32'h0);
    // Static phases: the quadrant of I/Q names the chosen oscillator
    for (int x = 0; x < 4; x++) begin
      apb(1, 12'h010 + 4 * x, 0);
      apb(1, 12'h020 + 4 * x, 0);
      apb(1, 12'h030 + 4 * x, x << 14);
      apb(1, 12'h040 + 4 * x, x << 14);
    end
    smp <= 12'h400;
    for (int j = 0; j < 8; j++) begin
      sl = j[2] ? ~j[1:0] : j[1:0];
      hop_a <= j[2] ? j[1:0] : ~j[1:0];
      hop_b <= j[2] ? j[1:0] : ~j[1:0];
      apb(1, 12'h004, {28'h0, sl, sl});
      apb(1, 12'h000, {31'h0, j[2]});
      repeat (40) @(posedge pclk);
      chk(quad(ai, aq), j[1:0]);
      chk(quad(bi, bq), j[1:0]);
    end
    for (int j = 0; j < 3; j++) begin
      apb(1, 12'h000, j == 0 ? 32'h0a : (j == 1 ? 32'h8a : 32'h08));
      fork
        link.sync_cycle();
        watch(40);
      join
      chk(n_cgs, j == 0);
      chk(n_sev, j < 2);
    end
    apb(1, 12'h000, 32'h08);
    fork
      link.sysref_run(4, 40);
      begin
        repeat (60) @(posedge pclk);
        apb(1, 12'h000, 32'h0c);
      end
      watch(170);
    join
    chk(n_sev, 1);
    apb(0, 12'h000, 0);
    chk(rd, 32'h08);
    apb(1, 12'h000, 32'h0c);
    fork
      link.sysref_run(1, 40);
      watch(50);
    join
    chk(n_sev, 1);
    for (int d = 0; d < 4; d++) begin
      apb(1, 12'h000, d << 5);
      gap();
      gap();
      gap();
      chk(n, 4 << d);
    end
    final_report();
  end
endmodule // test_ddc_nco_select_sync_decimation

bind dns_ddc_top dns_ddc_props #(.OW(OW)) u_props (.pclk(pclk), .presetn(presetn),
  .single_ended_sync_pin(single_ended_sync_pin), .sysref_pin(sysref_pin),
  .out_a_i(out_a_i), .out_a_q(out_a_q), .out_a_valid(out_a_valid),
  .out_b_valid(out_b_valid), .cgs_start(cgs_start), .nco_sync_event(nco_sync_event));
